// file: core/ilp_input_path_config.sv
/*
  Input loop receiver and feedback-path control registers with decoded
  controls for the analog receivers, divider and reference selection.
  Assumes the serial control port gives one-cycle byte write strobes and
  samples read data one cycle after presenting the address.
*/
`timescale 1ns/1ps
module ilp_input_path_config (
  input  wire logic                         mclk,           // 40 MHz clock.
  input  wire logic                         arst_n,         // Async reset.
  input  wire logic                         reg_wr,         // Write strobe.
  input  wire logic [ilp_pkg::ADDR_W-1:0]   reg_addr,       // Register address.
  input  wire logic [ilp_pkg::DATA_W-1:0]   reg_wdata,      // Write data.
  output logic      [ilp_pkg::DATA_W-1:0]   reg_rdata,      // Read data.
  input  wire logic                         reference_a_diff_en,   // Ref a diff mode.
  input  wire logic                         reference_b_diff_en,   // Ref b diff mode.
  input  wire logic [ilp_pkg::RDIV_W-1:0]   reference_a_rdiv_cfg,  // Ref a divider.
  input  wire logic [ilp_pkg::RDIV_W-1:0]   reference_b_rdiv_cfg,  // Ref b divider.
  input  wire logic                         clock_fail,     // Clocks lost.
  input  wire logic                         ref_sel_pin,    // Select pin.
  output logic                              fb_from_vcxo,   // Local feedback.
  output logic                              fb_internal_zd, // Channel 0 path.
  output logic                              zd_rx_enable,   // ZD receiver on.
  output logic                              zd_rx_diff,     // ZD differential.
  output logic                              zd_pin_sel,     // ZD pin choice.
  output logic                              reference_a_pin_sel,   // Ref a pin choice.
  output logic                              reference_b_pin_sel,   // Ref b pin choice.
  output logic      [ilp_pkg::RDIV_W-1:0]   reference_b_rdiv_eff,  // Ref b divider.
  output logic                              tune_midsupply, // Force Vcc/2.
  output logic                              cp_tristate,    // Pump high-Z.
  output ilp_pkg::ilp_sel_t                 ref_sel_mode,   // Selection mode.
  output logic                              ref_want_b      // Ref b demanded.
);
  import ilp_pkg::*;

  logic [7:0]  rx_reg;
  logic [7:0]  rx_next;
  logic [7:0]  misc_reg;
  logic [7:0]  misc_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  ilp_sel_if   sel_bus ();

  // Register writes; reserved bits are dropped so they always read zero.
  always_comb begin
    rx_next   = rx_reg;
    misc_next = misc_reg;
    if (reg_wr && reg_addr == ADDR_RX_FB) begin
      rx_next = reg_wdata & RX_FB_MASK;
    end
    if (reg_wr && reg_addr == ADDR_MISC) begin
      misc_next = reg_wdata & MISC_MASK;
    end
    rdata_next = RDATA_UNMAPPED;
    if (reg_addr == ADDR_RX_FB) begin
      rdata_next = rx_reg;
    end else if (reg_addr == ADDR_MISC) begin
      rdata_next = misc_reg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_reg    <= RX_FB_RESET;
      misc_reg  <= MISC_RESET;
      rdata_reg <= RDATA_UNMAPPED;
    end else begin
      rx_reg    <= rx_next;
      misc_reg  <= misc_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // The selection field goes to the decoder together with the pin.
  assign sel_bus.mode    = misc_reg[MISC_MODE_HI:MISC_MODE_LO];
  assign sel_bus.sel_pin = ref_sel_pin;

  ilp_sel_decode u_sel (
    .s (sel_bus.dec)
  );

  // Decoded controls, registered so the analog side sees clean levels.
  logic              fbv_next;
  logic              fbi_next;
  logic              zde_next;
  logic              zdd_next;
  logic              zdp_next;
  logic              rap_next;
  logic              rbp_next;
  logic [RDIV_W-1:0] rdiv_next;
  logic              mid_next;
  logic              cpt_next;
  ilp_sel_t          mode_next;
  logic              wantb_next;

  // A pin choice is held at zero while its receiver is differential, since
  // the choice has no meaning then and a stable level eases checking.
  always_comb begin
    fbv_next   = rx_reg[RX_FB_VCXO];
    fbi_next   = !rx_reg[RX_FB_VCXO] && rx_reg[RX_ZD_TYPE];
    zde_next   = !rx_reg[RX_FB_VCXO] && !rx_reg[RX_ZD_TYPE];
    zdd_next   = rx_reg[RX_ZD_DIFF];
    zdp_next   = !rx_reg[RX_ZD_DIFF] && rx_reg[RX_ZD_PIN];
    rap_next   = !reference_a_diff_en && rx_reg[RX_REFERENCE_A_PIN];
    rbp_next   = !reference_b_diff_en && rx_reg[RX_REFERENCE_B_PIN];
    rdiv_next  = misc_reg[MISC_REFERENCE_B_INDEP] ? reference_b_rdiv_cfg
                                           : reference_a_rdiv_cfg;
    mid_next   = clock_fail && misc_reg[MISC_MIDSUPPLY];
    cpt_next   = clock_fail && !misc_reg[MISC_MIDSUPPLY];
    mode_next  = sel_bus.sel;
    wantb_next = sel_bus.want_b;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fb_from_vcxo   <= 1'b0;
      fb_internal_zd <= 1'b0;
      zd_rx_enable   <= 1'b0;
      zd_rx_diff     <= 1'b0;
      zd_pin_sel     <= 1'b0;
      reference_a_pin_sel   <= 1'b0;
      reference_b_pin_sel   <= 1'b0;
      reference_b_rdiv_eff  <= '0;
      tune_midsupply <= 1'b0;
      cp_tristate    <= 1'b0;
      ref_sel_mode   <= ILP_SEL_NONREVERT;
      ref_want_b     <= 1'b0;
    end else begin
      fb_from_vcxo   <= fbv_next;
      fb_internal_zd <= fbi_next;
      zd_rx_enable   <= zde_next;
      zd_rx_diff     <= zdd_next;
      zd_pin_sel     <= zdp_next;
      reference_a_pin_sel   <= rap_next;
      reference_b_pin_sel   <= rbp_next;
      reference_b_rdiv_eff  <= rdiv_next;
      tune_midsupply <= mid_next;
      cp_tristate    <= cpt_next;
      ref_sel_mode   <= mode_next;
      ref_want_b     <= wantb_next;
    end
  end

  // Checks on the decoded controls and reserved bits; all but AST_RESERVED_ZERO span the register stage.
  // The release edge still runs the reset branch, so checks whose outputs
  // would sit at reset levels there gate on the sampled reset input.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_ZD_TYPE_IGNORED: assert property (
    rx_reg[RX_FB_VCXO] |=> fb_from_vcxo && !fb_internal_zd && !zd_rx_enable)
    else $error("Zero delay type acted with vcxo feedback selected.");

  AST_ZD_INTERNAL: assert property (
    reg_wr && reg_addr == ADDR_RX_FB && reg_wdata[5:4] == 2'b10
    |=> ##1 fb_internal_zd && !zd_rx_enable)
    else $error("Internal zero delay did not power down the receiver.");

  AST_ZD_EXTERNAL: assert property (
    arst_n && !rx_reg[RX_FB_VCXO] && !rx_reg[RX_ZD_TYPE] |=> zd_rx_enable)
    else $error("External zero delay did not enable the receiver.");

  AST_FB_SOURCE: assert property (
    ##1 fb_from_vcxo == $past(rx_reg[RX_FB_VCXO]))
    else $error("Feedback source does not follow its bit.");

  AST_ZD_DIFF_PIN: assert property (
    rx_reg[RX_ZD_DIFF] |=> zd_rx_diff && !zd_pin_sel)
    else $error("Zero delay pin choice active in differential mode.");

  AST_REFERENCE_B_PIN: assert property (
    !reference_b_diff_en && rx_reg[RX_REFERENCE_B_PIN] |=> reference_b_pin_sel)
    else $error("Reference b pin choice lost.");

  AST_REFERENCE_A_PIN: assert property (
    reference_a_diff_en |=> !reference_a_pin_sel)
    else $error("Reference a pin choice active in differential mode.");

  AST_RDIV_SHARE: assert property (
    arst_n && !misc_reg[MISC_REFERENCE_B_INDEP]
    |=> reference_b_rdiv_eff == $past(reference_a_rdiv_cfg))
    else $error("Reference b divider not shared from reference a.");

  AST_RDIV_OWN: assert property (
    misc_reg[MISC_REFERENCE_B_INDEP] |=> reference_b_rdiv_eff == $past(reference_b_rdiv_cfg))
    else $error("Reference b divider not its own setting.");

  AST_FAIL_ACTION: assert property (
    clock_fail |=> tune_midsupply != cp_tristate)
    else $error("Clock failure took no tune voltage action.");

  AST_MODE_PIN: assert property (
    misc_reg[MISC_MODE_HI] |=> ref_sel_mode == ILP_SEL_PIN
                              && ref_want_b == $past(ref_sel_pin))
    else $error("Pin mode did not follow the select pin.");

  AST_MODE_FORCE_B: assert property (
    misc_reg[4:2] == 3'b011 |=> ref_sel_mode == ILP_SEL_FORCE_B)
    else $error("Force reference b not decoded.");

  AST_RESERVED_ZERO: assert property (
    (rx_reg & ~RX_FB_MASK) == 8'h00 && (misc_reg & ~MISC_MASK) == 8'h00)
    else $error("Reserved register bits hold a one.");

  AST_ZD_SINGLE: assert property (
    arst_n && !rx_reg[RX_ZD_DIFF]
    |=> !zd_rx_diff && zd_pin_sel == $past(rx_reg[RX_ZD_PIN]))
    else $error("Zero delay receiver not single-ended as programmed.");

  AST_REFERENCE_B_DIFF: assert property (
    reference_b_diff_en |=> !reference_b_pin_sel)
    else $error("Reference b pin choice active in differential mode.");

  AST_REFERENCE_A_SINGLE: assert property (
    !reference_a_diff_en && rx_reg[RX_REFERENCE_A_PIN] |=> reference_a_pin_sel)
    else $error("Reference a pin choice lost.");

  AST_MODE_NONREVERT: assert property (
    arst_n && misc_reg[MISC_MODE_HI:MISC_MODE_LO] == 3'b000
    |=> ref_sel_mode == ILP_SEL_NONREVERT && ref_want_b)
    else $error("Nonrevertive mode does not stay on reference b.");

  AST_MODE_REVERT: assert property (
    misc_reg[MISC_MODE_HI:MISC_MODE_LO] == 3'b001
    |=> ref_sel_mode == ILP_SEL_REVERT_A && !ref_want_b)
    else $error("Revert mode does not ask for reference a.");

  COV_INTERNAL_ZD: cover property (fb_internal_zd);
  COV_PIN_B: cover property (ref_sel_mode == ILP_SEL_PIN && ref_want_b);
  COV_MIDSUPPLY: cover property (tune_midsupply);
  COV_OWN_DIV: cover property (misc_reg[MISC_REFERENCE_B_INDEP] ##1 reg_wr);
  COV_REVERT_A: cover property (ref_sel_mode == ILP_SEL_REVERT_A);
endmodule

// file: core/ilp_pkg.sv
/*
  Constants for the input loop receiver and feedback configuration block.
  Assumes a register file reached by the serial control port's byte access.
*/
// Overview of operation
// - Zero delay type bit counts only while the feedback source bit is 0.
// - Type 1: zero delay receiver off, channel 0 feedback; 0: receiver on.
// - Feedback source 1 uses the vcxo input; 0 enables zero delay operation.
// - Bit 2 sets zero delay receiver differential; 0 means single-ended.
// - Bit 3 picks the single-ended zero delay pin, only when bit 2 is 0.
// - Bit 1 picks reference b single-ended pin while its differential is off.
// - Bit 0 picks reference a single-ended pin while its differential is off.
// - Misc bit 7 at 1 divides reference b by its own divider setting.
// - Misc bit 7 at 0 gives reference b the reference a divider setting.
// - On clock failure bit 6 forces midsupply tune voltage, else tristate pump.
// - Reference selection mode is bits 4 to 2, reset value 000.
// - Mode bit 4 at 0 decodes nonrevertive, revert a, force a, force b.
// - Mode bit 4 at 1 follows the select pin: low a, high b.
package ilp_pkg;
  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 8;
  localparam int          RDIV_W          = 16;
  localparam logic [9:0]  ADDR_RX_FB      = 10'h01B;
  localparam logic [9:0]  ADDR_MISC       = 10'h01C;
  localparam logic [7:0]  RX_FB_RESET     = 8'h00;
  localparam logic [7:0]  MISC_RESET      = 8'h00;
  localparam logic [7:0]  RX_FB_MASK      = 8'h3F;
  localparam logic [7:0]  MISC_MASK       = 8'hDC;
  localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;
  // Field positions in the receiver and feedback control register.
  localparam int          RX_ZD_TYPE      = 5;
  localparam int          RX_FB_VCXO      = 4;
  localparam int          RX_ZD_PIN       = 3;
  localparam int          RX_ZD_DIFF      = 2;
  localparam int          RX_REFERENCE_B_PIN     = 1;
  localparam int          RX_REFERENCE_A_PIN     = 0;
  // Field positions in the miscellaneous control register.
  localparam int          MISC_REFERENCE_B_INDEP = 7;
  localparam int          MISC_MIDSUPPLY  = 6;
  localparam int          MISC_MODE_HI    = 4;
  localparam int          MISC_MODE_LO    = 2;
  localparam logic [2:0]  MODE_RESET      = 3'h0;

  typedef enum logic [2:0] {
    ILP_SEL_NONREVERT = 3'b000,
    ILP_SEL_REVERT_A  = 3'b001,
    ILP_SEL_FORCE_A   = 3'b010,
    ILP_SEL_FORCE_B   = 3'b011,
    ILP_SEL_PIN       = 3'b100
  } ilp_sel_t;
endpackage

// file: core/ilp_sel_if.sv
/*
  Carrier between the configuration block and its selection decoder.
  Assumes both ends share one clock domain; the decoder is combinational.
*/
`timescale 1ns/1ps
interface ilp_sel_if;
  logic [2:0]        mode;     // Reference selection mode field.
  logic              sel_pin;  // Reference select pin level.
  ilp_pkg::ilp_sel_t sel;      // Decoded selection behaviour.
  logic              want_b;   // Reference b demanded by nonrevertive, force b or pin.
  logic              forced;   // Manual selection, no automatic switching.
  modport cfg (output mode, output sel_pin, input sel, input want_b,
               input forced);
  modport dec (input mode, input sel_pin, output sel, output want_b,
               output forced);
endinterface

// file: core/ilp_sel_decode.sv
/*
  Decoder of the reference selection mode field into a selection behaviour.
  Assumes the select pin is synchronous to the block clock.
*/
`timescale 1ns/1ps
module ilp_sel_decode (
  ilp_sel_if.dec s  // Mode in, decoded selection out.
);
  import ilp_pkg::*;

  // The pin only matters once the top mode bit hands control to it.
  always_comb begin
    s.sel    = ILP_SEL_NONREVERT;
    s.want_b = 1'b0;
    s.forced = 1'b0;
    if (s.mode[2]) begin
      s.sel    = ILP_SEL_PIN;
      s.want_b = s.sel_pin;
      s.forced = 1'b1;
    end else begin
      unique case (s.mode[1:0])
        2'b00: begin
          s.sel    = ILP_SEL_NONREVERT;
          s.want_b = 1'b1;
        end
        2'b01: begin
          s.sel    = ILP_SEL_REVERT_A;
          s.want_b = 1'b0;
        end
        2'b10: begin
          s.sel    = ILP_SEL_FORCE_A;
          s.forced = 1'b1;
        end
        2'b11: begin
          s.sel    = ILP_SEL_FORCE_B;
          s.want_b = 1'b1;
          s.forced = 1'b1;
        end
      endcase
    end
  end
endmodule

// file: sim/tb.sv
/*
  Self-checking bench for the input loop receiver and feedback control block.
  Assumes the block's one-cycle write strobe and one-cycle registered read.
*/
`timescale 1ns/1ps
module tb;
  import ilp_pkg::*;
  logic        mclk, arst_n, reg_wr, reference_a_diff_en, reference_b_diff_en;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] reference_a_rdiv_cfg, reference_b_rdiv_cfg, reference_b_rdiv_eff;
  logic        clock_fail, ref_sel_pin, fb_from_vcxo, fb_internal_zd;
  logic        zd_rx_enable, zd_rx_diff, zd_pin_sel, reference_a_pin_sel;
  logic        reference_b_pin_sel, tune_midsupply, cp_tristate, ref_want_b;
  ilp_sel_t    ref_sel_mode;
  int          n_errors, n_checks, cycles;

  ilp_input_path_config u_ilp_input_path_config (
    .mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reference_a_diff_en(reference_a_diff_en), .reference_b_diff_en(reference_b_diff_en),
    .reference_a_rdiv_cfg(reference_a_rdiv_cfg), .reference_b_rdiv_cfg(reference_b_rdiv_cfg),
    .clock_fail(clock_fail), .ref_sel_pin(ref_sel_pin),
    .fb_from_vcxo(fb_from_vcxo), .fb_internal_zd(fb_internal_zd),
    .zd_rx_enable(zd_rx_enable), .zd_rx_diff(zd_rx_diff),
    .zd_pin_sel(zd_pin_sel), .reference_a_pin_sel(reference_a_pin_sel),
    .reference_b_pin_sel(reference_b_pin_sel), .reference_b_rdiv_eff(reference_b_rdiv_eff),
    .tune_midsupply(tune_midsupply), .cp_tristate(cp_tristate),
    .ref_sel_mode(ref_sel_mode), .ref_want_b(ref_want_b));

  // Free-running 40 MHz clock.
  always #12.5 mclk = ~mclk;

  // Compare one value, counting every check and every mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; waits until decoded outputs have settled.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // Present an address and compare the registered read data.
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
    chk(reg_rdata, e);
  endtask

  // Defaults after reset: all fields zero, nonrevertive selection.
  task automatic t_reset;
    rd(ADDR_MISC, 8'h00);
    rd(ADDR_RX_FB, 8'h00);
    chk(ref_sel_mode, ILP_SEL_NONREVERT);
    chk(ref_want_b, 1'b1);
    chk(zd_rx_enable, 1'b1);
  endtask

  // Every combination of feedback source and zero delay type.
  task automatic t_feedback;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RX_FB, 8'(i << 4));
      chk(fb_from_vcxo, i[0]);
      chk(fb_internal_zd, !i[0] && i[1]);
      chk(zd_rx_enable, !i[0] && !i[1]);
    end
  endtask

  // Receiver modes and pin choices against the differential enables.
  task automatic t_receivers;
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk);
      reference_a_diff_en <= i[4];
      reference_b_diff_en <= i[4] ^ i[0];
      wr(ADDR_RX_FB, 8'(i[3:0]));
      chk(zd_rx_diff, i[2]);
      chk(zd_pin_sel, !i[2] && i[3]);
      chk(reference_a_pin_sel, !i[4] && i[0]);
      chk(reference_b_pin_sel, !(i[4] ^ i[0]) && i[1]);
    end
  endtask

  // All defined bits set, reserved ones written as zero; unmapped writes
  // leave no trace.
  task automatic t_reserved;
    wr(ADDR_RX_FB, 8'h3F);
    rd(ADDR_RX_FB, 8'h3F);
    wr(ADDR_MISC, 8'hDC);
    rd(ADDR_MISC, 8'hDC);
    wr(10'h01D, 8'hA5);
    rd(10'h01D, 8'h00);
    rd(ADDR_RX_FB, 8'h3F);
  endtask

  // Divider tracking and the failure behaviour of the tune voltage.
  // The references are taken as equal in frequency while the divider is
  // shared, so the loop would stay locked on either setting.
  task automatic t_divider_fail;
    @(posedge mclk);
    reference_a_rdiv_cfg <= 16'h1234;
    reference_b_rdiv_cfg <= 16'hABCD;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      clock_fail <= i[2];
      wr(ADDR_MISC, {i[0], i[1], 6'h00});
      chk(reference_b_rdiv_eff, i[0] ? 16'hABCD : 16'h1234);
      chk(tune_midsupply, i[2] && i[1]);
      chk(cp_tristate, i[2] && !i[1]);
    end
  endtask

  // All selection modes with the select pin at both levels.
  task automatic t_select;
    logic [2:0] m;
    logic       w;
    for (int i = 0; i < 16; i++) begin
      m = i[2:0];
      w = m[2] ? i[3] : (m[1:0] == 2'b00 || m[1:0] == 2'b11);
      @(posedge mclk);
      ref_sel_pin <= i[3];
      wr(ADDR_MISC, {3'b000, m, 2'b00});
      rd(ADDR_MISC, {3'b000, m, 2'b00});
      chk(ref_sel_mode, m[2] ? ILP_SEL_PIN : m);
      chk(ref_want_b, w);
    end
  endtask

  // The single place where the run ends.
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    reference_a_diff_en = 1'b0;
    reference_b_diff_en = 1'b0;
    reference_a_rdiv_cfg = 16'h0000;
    reference_b_rdiv_cfg = 16'h0000;
    clock_fail = 1'b0;
    ref_sel_pin = 1'b0;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_feedback();
    t_receivers();
    t_reserved();
    t_divider_fail();
    t_select();
    stop_test();
  end
endmodule
